// ---- verilog/iuvfr_top.v ----
// Purpose: input under-voltage fault response sequencer with power-good
// Assumes: command port driven by the bus controller on clk_sys
// Notes: output_on is the regulator enable; fault pins are synchronised
`timescale 1ns/1ps
`include "iuvfr_defines.vh"
module iuvfr_top #(
    parameter UNIT_W = 24
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // command port
    input wire cmd_wr,
    input wire cmd_rd,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    output reg [15:0] cmd_rdata,
    output reg cmd_ack,
    output reg cmd_nack,
    // fault and control pins
    input wire uv_fault_pin,
    input wire ctrl_on_pin,
    input wire bias_ok_pin,
    input wire other_fault_pin,
    // measured output voltage, same format as threshold
    input wire [15:0] vout_code,
    // outputs
    output reg output_on,
    output reg output_good_flag,
    output reg uv_latched,
    output reg [2:0] attempts
);
    localparam ST_OFF = 6'h01;
    localparam ST_RUN = 6'h02;
    localparam ST_CONT = 6'h04;
    localparam ST_WAIT = 6'h08;
    localparam ST_HOLD = 6'h10;
    localparam ST_LATCH = 6'h20;

    reg [7:0] uv_action;
    reg [15:0] good_on;
    reg [15:0] time_unit;
    reg [3:0] sync1;
    reg [3:0] sync2;
    reg [5:0] state;
    reg [5:0] next_state;
    reg next_on;
    reg tmr_start;
    reg clear_req;
    wire tmr_done;
    wire uv_fault = sync2[0];
    wire run_req = sync2[1] & sync2[2];
    wire other_fault = sync2[3];
    wire [1:0] resp = uv_action[`IUVFR_RESP_HI:`IUVFR_RESP_LO];
    wire [2:0] retry_set = uv_action[`IUVFR_RETRY_HI:`IUVFR_RETRY_LO];
    wire [2:0] delay_exp = uv_action[`IUVFR_DELAY_HI:`IUVFR_DELAY_LO];
    wire [UNIT_W-1:0] unit_cycles;
    wire [31:0] unit_product;
    wire retry_left = (retry_set == `IUVFR_RETRY_FOREVER) || (attempts < retry_set);

    // unit length: (register + 1) base steps
    // unit from time register
    assign unit_product = ({8'h00, time_unit} + 24'h000001) * `IUVFR_UNIT_STEP_CYC;
    assign unit_cycles = unit_product[UNIT_W-1:0];

    // two-flop synchronisers for the pins
    always @(posedge clk_sys) begin
        if (srst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {other_fault_pin, bias_ok_pin, ctrl_on_pin, uv_fault_pin};
            sync2 <= sync1;
        end
    end

    // command port: writes, reads and clear command
    always @(posedge clk_sys) begin
        if (srst) begin
            uv_action <= `IUVFR_RST_UV_ACTION;
            good_on <= `IUVFR_RST_GOOD_ON;
            time_unit <= `IUVFR_RST_TIME_UNIT;
            cmd_rdata <= 16'h0000;
            cmd_ack <= 1'b0;
            cmd_nack <= 1'b0;
            clear_req <= 1'b0;
        end else begin
            cmd_ack <= 1'b0;
            cmd_nack <= 1'b0;
            clear_req <= 1'b0;
            if (cmd_wr || cmd_rd) begin
                if (cmd_code == `IUVFR_CMD_UV_ACTION) begin
                    cmd_ack <= 1'b1;
                    cmd_rdata <= {8'h00, uv_action};
                    if (cmd_wr) begin
                        uv_action <= cmd_wdata[7:0];
                    end
                end else if (cmd_code == `IUVFR_CMD_GOOD_ON) begin
                    cmd_ack <= 1'b1;
                    cmd_rdata <= good_on;
                    if (cmd_wr) begin
                        good_on <= cmd_wdata;
                    end
                end else if (cmd_code == `IUVFR_CMD_TIME_UNIT) begin
                    cmd_ack <= 1'b1;
                    cmd_rdata <= time_unit;
                    if (cmd_wr) begin
                        time_unit <= cmd_wdata;
                    end
                end else if (cmd_code == `IUVFR_CMD_CLEAR && cmd_wr) begin
                    cmd_ack <= 1'b1;
                    clear_req <= 1'b1;
                end else begin
                    cmd_nack <= 1'b1;
                    cmd_rdata <= 16'h0000;
                end
            end
        end
    end

    // next-state logic of the fault sequencer
    always @* begin
        next_state = state;
        next_on = output_on;
        tmr_start = 1'b0;
        case (state)
            ST_OFF: begin
                next_on = 1'b0;
                if (run_req && !other_fault) begin
                    next_state = ST_RUN;
                    next_on = 1'b1;
                end
            end
            ST_RUN: begin
                next_on = 1'b1;
                if (uv_fault && resp == `IUVFR_RESP_CONTINUE) begin
                    next_state = ST_CONT;
                    tmr_start = 1'b1;
                end else if (uv_fault && resp == `IUVFR_RESP_RETRY) begin
                    next_on = 1'b0;
                    tmr_start = 1'b1;
                    next_state = (retry_set == `IUVFR_RETRY_NONE) ? ST_LATCH : ST_WAIT;
                end else if (uv_fault && resp == `IUVFR_RESP_HOLD) begin
                    next_on = 1'b0;
                    next_state = ST_HOLD;
                end
            end
            ST_CONT: begin
                next_on = 1'b1;
                if (!uv_fault) begin
                    next_state = ST_RUN;
                end else if (tmr_done) begin
                    next_on = 1'b0;
                    tmr_start = 1'b1;
                    next_state = (retry_set == `IUVFR_RETRY_NONE) ? ST_LATCH : ST_WAIT;
                end
            end
            ST_WAIT: begin
                next_on = 1'b0;
                if (tmr_done) begin
                    if (!uv_fault) begin
                        next_state = ST_RUN;
                        next_on = 1'b1;
                    end else if (retry_left) begin
                        tmr_start = 1'b1;
                    end else begin
                        next_state = ST_LATCH;
                    end
                end
            end
            ST_HOLD: begin
                next_on = 1'b0;
                if (!uv_fault) begin
                    next_state = ST_RUN;
                    next_on = 1'b1;
                end
            end
            ST_LATCH: begin
                next_on = 1'b0;
                if (clear_req && !uv_fault) begin
                    next_state = ST_OFF;
                end
            end
            default: begin
                next_state = ST_OFF;
                next_on = 1'b0;
            end
        endcase
        // off command, bias loss or other fault end it
        if (!run_req) begin
            next_state = ST_OFF;
            next_on = 1'b0;
        end else if (other_fault) begin
            next_state = ST_LATCH;
            next_on = 1'b0;
        end
    end

    // state, enable, attempt counter, power good
    always @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_OFF;
            output_on <= 1'b0;
            output_good_flag <= 1'b0;
            uv_latched <= 1'b0;
            attempts <= 3'h0;
        end else begin
            state <= next_state;
            output_on <= next_on;
            uv_latched <= (next_state == ST_LATCH);
            if (next_state == ST_OFF || next_state == ST_RUN) begin
                attempts <= 3'h0;
            end else if (state == ST_WAIT && tmr_done && uv_fault && retry_left
                         && retry_set != `IUVFR_RETRY_FOREVER) begin
                attempts <= attempts + 3'h1;
            end
            output_good_flag <= next_on && (vout_code >= good_on);
        end
    end

    iuvfr_delay_timer #(
        .UNIT_W(UNIT_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .srst(srst),
        .start(tmr_start),
        .stop(next_state == ST_OFF || next_state == ST_RUN),
        .unit_cycles(unit_cycles),
        .exp_sel(delay_exp),
        .busy(),
        .done(tmr_done)
    );
endmodule

// ---- pkg/iuvfr_defines.vh ----
// Purpose: constants for the input under-voltage fault response block
// Assumes: 50 MHz system clock
// Notes: command codes other than clear double as register addresses on the command port
`ifndef IUVFR_DEFINES_VH
`define IUVFR_DEFINES_VH

// command codes
`define IUVFR_CMD_CLEAR 8'h03
`define IUVFR_CMD_UV_ACTION 8'h5A
`define IUVFR_CMD_GOOD_ON 8'h5E
`define IUVFR_CMD_TIME_UNIT 8'hD2

// fault action field positions
`define IUVFR_RESP_HI 7
`define IUVFR_RESP_LO 6
`define IUVFR_RETRY_HI 5
`define IUVFR_RETRY_LO 3
`define IUVFR_DELAY_HI 2
`define IUVFR_DELAY_LO 0

// response codes
`define IUVFR_RESP_IGNORE 2'h0
`define IUVFR_RESP_CONTINUE 2'h1
`define IUVFR_RESP_RETRY 2'h2
`define IUVFR_RESP_HOLD 2'h3

// retry codes
`define IUVFR_RETRY_NONE 3'h0
`define IUVFR_RETRY_FOREVER 3'h7

// reset values
`define IUVFR_RST_UV_ACTION 8'h80
`define IUVFR_RST_GOOD_ON 16'h0000
`define IUVFR_RST_TIME_UNIT 16'h0000

// timing: one base step of the time unit register
`define IUVFR_CLK_PERIOD_NS 20
`define IUVFR_UNIT_STEP_NS 1000
`define IUVFR_UNIT_STEP_CYC (`IUVFR_UNIT_STEP_NS / `IUVFR_CLK_PERIOD_NS)

`endif

// ---- verilog/iuvfr_delay_timer.v ----
// Purpose: counts 2^exp delay units, each unit a programmable number of cycles
// Assumes: start is a one-cycle pulse; restart while busy reloads
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
module iuvfr_delay_timer #(
    parameter UNIT_W = 24
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // control
    input wire start,
    input wire stop,
    input wire [UNIT_W-1:0] unit_cycles,
    input wire [2:0] exp_sel,
    // status
    output reg busy,
    output reg done
);
    reg [UNIT_W-1:0] pre_cnt;
    reg [7:0] unit_cnt;
    reg [7:0] unit_last;

    // prescaler makes one unit, unit counter counts 2^n of them
    always @(posedge clk_sys) begin
        if (srst) begin
            busy <= 1'b0;
            done <= 1'b0;
            pre_cnt <= {UNIT_W{1'b0}};
            unit_cnt <= 8'h00;
            unit_last <= 8'h00;
        end else begin
            done <= 1'b0;
            if (stop) begin
                busy <= 1'b0;
            end else if (start) begin
                busy <= 1'b1;
                pre_cnt <= {UNIT_W{1'b0}};
                unit_cnt <= 8'h00;
                unit_last <= (8'h01 << exp_sel) - 8'h01;
            end else if (busy) begin
                if (pre_cnt >= unit_cycles - {{(UNIT_W-1){1'b0}}, 1'b1}) begin
                    pre_cnt <= {UNIT_W{1'b0}};
                    if (unit_cnt == unit_last) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        unit_cnt <= unit_cnt + 8'h01;
                    end
                end else begin
                    pre_cnt <= pre_cnt + {{(UNIT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ---- verification/iuvfr_chk.sv ----
// Purpose: port-level assertions for the under-voltage fault response block
// Assumes: single clock domain, synchronous active-high reset
// Notes: act shadows the fault action register from command-port writes
`timescale 1ns/1ps
module iuvfr_chk #(
    parameter UNIT_W = 24
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // command port
    input wire cmd_wr,
    input wire cmd_rd,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire [15:0] cmd_rdata,
    input wire cmd_ack,
    input wire cmd_nack,
    // pins
    input wire uv_fault_pin,
    input wire ctrl_on_pin,
    input wire bias_ok_pin,
    input wire other_fault_pin,
    input wire [15:0] vout_code,
    // outputs
    input wire output_on,
    input wire output_good_flag,
    input wire uv_latched,
    input wire [2:0] attempts
);
    reg [7:0] act;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // shadow of the fault action register
    always @(posedge clk_sys) begin
        if (srst)
            act <= 8'h80;
        else if (cmd_wr && cmd_code == 8'h5A)
            act <= cmd_wdata[7:0];
    end
    a_ack_once: assert property ((cmd_wr || cmd_rd) |=> (cmd_ack ^ cmd_nack)) else $error("no single answer");
    a_no_stray: assert property (!(cmd_wr || cmd_rd) |=> !(cmd_ack || cmd_nack)) else $error("stray answer");
    a_good_on: assert property (output_good_flag |-> output_on) else $error("good while off");
    a_latch_off: assert property (uv_latched |-> !output_on) else $error("on while latched");
    a_ignore_on: assert property ((act[7:6] == 2'h0 && output_on && ctrl_on_pin && bias_ok_pin &&
        !other_fault_pin && $rose(uv_fault_pin)) |=> output_on[*4]) else $error("ignored fault dropped output");
    a_disable_fast: assert property ((act[7] && output_on && $rose(uv_fault_pin))
        |-> ##[1:4] !output_on) else $error("output not disabled");
    a_retry_cap: assert property ((act[5:3] != 3'h7) |-> (attempts <= act[5:3])) else $error("too many");
    a_forever_count: assert property ((act[5:3] == 3'h7 && $stable(act))
        |-> ($stable(attempts) || attempts == 3'h0)) else $error("count moved");
    a_off_clear: assert property ((!ctrl_on_pin)[*4] |=>
        (attempts == 3'h0 && !output_on && !uv_latched)) else $error("off did not clear");
    c_latch: cover property ($rose(uv_latched));
    c_nack: cover property (cmd_nack);
    c_good: cover property ($rose(output_good_flag));
endmodule
bind iuvfr_top iuvfr_chk #(.UNIT_W(UNIT_W)) i_iuvfr_chk (.clk_sys(clk_sys), .srst(srst),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .uv_fault_pin(uv_fault_pin),
    .ctrl_on_pin(ctrl_on_pin), .bias_ok_pin(bias_ok_pin), .other_fault_pin(other_fault_pin),
    .vout_code(vout_code), .output_on(output_on), .output_good_flag(output_good_flag),
    .uv_latched(uv_latched), .attempts(attempts));

// ---- verification/iuvfr_host.sv ----
// Purpose: bus controller model issuing commands to the block
// Assumes: answer arrives one cycle after the taking edge
// Notes: released code and data lines show inverted values
`timescale 1ns/1ps
module iuvfr_host (
    // clock
    input wire clk_sys,
    // command port
    output reg cmd_wr,
    output reg cmd_rd,
    output reg [7:0] cmd_code,
    output reg [15:0] cmd_wdata,
    input wire [15:0] cmd_rdata,
    input wire cmd_ack,
    input wire cmd_nack
);
    // idle bus at time zero
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // one access; n is unknown when no answer came
    task xfer(input w, input [7:0] c, input [15:0] d, output [15:0] q, output n);
        begin
            @(posedge clk_sys);
            cmd_wr <= w;
            cmd_rd <= ~w;
            cmd_code <= c;
            cmd_wdata <= d;
            @(posedge clk_sys);
            cmd_wr <= 1'b0;
            cmd_rd <= 1'b0;
            cmd_code <= ~c;
            cmd_wdata <= ~d;
            @(posedge clk_sys);
            q = cmd_rdata;
            n = cmd_ack ? 1'b0 : (cmd_nack ? 1'b1 : 1'bx);
        end
    endtask
endmodule

// ---- verification/iuvfr_top_tb.sv ----
// Purpose: self-checking bench for the under-voltage fault response block
// Assumes: unit step 50 cycles, time unit register adds steps
// Notes: sequencer timing checked inside bounded windows
`timescale 1ns/1ps
module iuvfr_top_tb;
    reg clk_sys = 1'b0;
    reg srst = 1'b1;
    reg uv = 1'b0;
    reg con = 1'b0;
    reg bias = 1'b1;
    reg oth = 1'b0;
    reg [15:0] vout = 16'h0000;
    wire cmd_wr, cmd_rd, cmd_ack, cmd_nack, on, good, lat;
    wire [7:0] cmd_code;
    wire [15:0] cmd_wdata, cmd_rdata;
    wire [2:0] att;
    integer num_errors = 0;
    integer num_checks = 0;
    reg [15:0] rd;
    reg nak;
    always #10 clk_sys = ~clk_sys;
    iuvfr_top #(.UNIT_W(24)) i_iuvfr_top (.clk_sys(clk_sys), .srst(srst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
        .cmd_nack(cmd_nack), .uv_fault_pin(uv), .ctrl_on_pin(con), .bias_ok_pin(bias),
        .other_fault_pin(oth), .vout_code(vout), .output_on(on), .output_good_flag(good),
        .uv_latched(lat), .attempts(att));
    iuvfr_host i_iuvfr_host (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack));
    // value compare
    task chk(input [16:0] got, input [16:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input [7:0] c, input [15:0] d);
        begin
            i_iuvfr_host.xfer(1'b1, c, d, rd, nak);
            chk(nak, 16'h0000);
        end
    endtask
    task rdc(input [7:0] c, input [15:0] e);
        begin
            i_iuvfr_host.xfer(1'b0, c, 16'h0000, rd, nak);
            chk({nak, rd}, {1'b0, e});
        end
    endtask
    // wait bounded for {latched, on} pattern
    task wst(input [1:0] e, input integer max);
        begin
            while (max > 0 && {lat, on} !== e) begin
                @(posedge clk_sys);
                max = max - 1;
            end
            chk({lat, on}, e);
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // watchdog
    initial begin
        cyc(6000);
        num_errors = num_errors + 1;
        give_verdict;
    end
    // test sequence
    initial begin
        cyc(12);
        srst <= 1'b0;
        rdc(8'h5A, 16'h0080);
        rdc(8'h5E, 16'h0000);
        rdc(8'hD2, 16'h0000);
        wr(8'h5A, 16'hFFFF);
        rdc(8'h5A, 16'h00FF);
        i_iuvfr_host.xfer(1'b0, 8'h11, 16'h0000, rd, nak);
        chk({nak, rd}, {1'b1, 16'h0000});
        $display("test registers done");
        wr(8'h5E, 16'h1000);
        vout <= 16'h0FFF;
        con <= 1'b1;
        wst(2'b01, 10);
        chk(good, 16'h0000);
        vout <= 16'h1000;
        cyc(3);
        chk(good, 16'h0001);
        $display("test power good done");
        wr(8'h5A, 16'h0000);
        uv <= 1'b1;
        cyc(40);
        chk(on, 16'h0001);
        uv <= 1'b0;
        wr(8'h5A, 16'h0088);
        uv <= 1'b1;
        cyc(5);
        chk({lat, on}, 16'h0000);
        wst(2'b10, 300);
        chk(att, 16'h0001);
        uv <= 1'b0;
        cyc(60);
        chk({lat, on}, 16'h0002);
        wr(8'h03, 16'h0000);
        wst(2'b01, 10);
        chk(att, 16'h0000);
        $display("test disable and retry done");
        wr(8'h5A, 16'h00C0);
        uv <= 1'b1;
        cyc(300);
        chk({lat, on}, 16'h0000);
        uv <= 1'b0;
        wst(2'b01, 10);
        $display("test hold done");
        wr(8'hD2, 16'h0001);
        wr(8'h5A, 16'h0041);
        uv <= 1'b1;
        cyc(190);
        chk(on, 16'h0001);
        wst(2'b10, 40);
        uv <= 1'b0;
        wr(8'h03, 16'h0000);
        wst(2'b01, 10);
        wr(8'hD2, 16'h0000);
        $display("test continue done");
        wr(8'h5A, 16'h00B8);
        uv <= 1'b1;
        cyc(700);
        chk({lat, on, 11'h000, att}, 16'h0000);
        oth <= 1'b1;
        wst(2'b10, 10);
        oth <= 1'b0;
        con <= 1'b0;
        wst(2'b00, 10);
        uv <= 1'b0;
        con <= 1'b1;
        wst(2'b01, 10);
        bias <= 1'b0;
        wst(2'b00, 10);
        bias <= 1'b1;
        wst(2'b01, 10);
        $display("test endless retry done");
        give_verdict;
    end
endmodule
